// ### hcps_map.svh
// constants for the hub charge and power select block
// assumes inclusion from the design modules and the bench
`ifndef HCPS_MAP_SVH
`define HCPS_MAP_SVH
`define HCPS_PORTS 2
`define HCPS_VBUS_FILT_CYCLES 16
`define HCPS_OTP_PWRON_DLY_W 3
`define HCPS_RST_AUTO_DIS_N 1'b0
`define HCPS_RST_HICUR 1'b0
`define HCPS_RST_PWRON_DLY 3'h0
`define HCPS_RST_RMBL 2'h0
`define HCPS_ID_RESET 16'h0000
`endif

// ### hcps_pkg.sv
// types for the hub charge and power select block
// assumes hcps_map.svh is reachable on the include path
package hcps_pkg;
    typedef enum logic [2:0] {
        HCPS_BC_NONE,
        HCPS_BC_AUTO,
        HCPS_BC_DCP,
        HCPS_BC_CDP
    } hcps_bc_e;
    typedef enum logic [1:0] {
        HCPS_UP_SS,
        HCPS_UP_HS,
        HCPS_UP_FS
    } hcps_up_e;
endpackage : hcps_pkg

// ### hcps_vbus_filter.sv
// vbus presence synchroniser and glitch filter
// assumes one clock domain, clock enable freezing state
`timescale 1ns/1ps
`default_nettype none
`include "hcps_map.svh"
module hcps_vbus_filter #(
    parameter int FILT_CYCLES = `HCPS_VBUS_FILT_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // level
    input wire logic vbusRaw,
    output logic vbusStable
);
    localparam int CW = $clog2(FILT_CYCLES + 1);
    logic sync1_r;
    logic sync2_r;
    logic [CW-1:0] cnt_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else if (clkEn) begin
            sync1_r <= vbusRaw;
            sync2_r <= sync1_r;
        end
    end
    // output follows only after a full run of equal samples
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
            vbusStable <= 1'b0;
        end else if (clkEn) begin
            if (sync2_r == vbusStable) begin
                cnt_r <= '0;
            end else if (cnt_r == CW'(FILT_CYCLES - 1)) begin
                cnt_r <= '0;
                vbusStable <= sync2_r;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : hcps_vbus_filter
`default_nettype wire

// ### hcps_strap_latch.sv
// strap sampler: captures straps at the first enabled edge after reset release
// assumes straps are steady around the release of reset
`timescale 1ns/1ps
`default_nettype none
`include "hcps_map.svh"
module hcps_strap_latch #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // straps
    input wire logic [W-1:0] strapIn,
    output logic [W-1:0] strapHeld,
    output logic strapValid
);
    // a constant under reset, capture after the release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strapHeld <= '0;
            strapValid <= 1'b0;
        end else if (clkEn && !strapValid) begin
            strapHeld <= strapIn;
            strapValid <= 1'b1;
        end
    end
endmodule : hcps_strap_latch
`default_nettype wire

// ### hcps_charge_power.sv
// hub downstream charging mode, port power switch and speed limiting
// assumes straps steady at reset release; all inputs synchronous to ref_clk
//
// Overview of operation
// - one charging enable bit per downstream port, individually switched
// - automatic charger selection active after reset unless disabled
// - automatic mode toggles divider and dedicated signalling per attached device
// - default divider advertises up to 5 W
// - high current divider bit raises advertisement to 10 W
// - never charging-downstream-port behaviour while automatic mode on
// - mode from enable, vbus above 4 V and disable bit
// - per-port charging enable strap shared with power enable pin
// - switched power per port or ganged, with overcurrent inputs
// - configuration bits disable switching and select ganged control
// - active-low strap and ganged strap offer the same choices
// - power enable outputs active high or low by polarity bit
// - polarity may also come from a strap
// - host programs otp through vendor requests, device carries them out
// - only ids, removable, auto, high current, power-on delay come from otp
// - stored removable bit inverted before use
// - high or full speed upstream disables superspeed downstream
// - full speed only upstream also disables high speed downstream
// - straps sampled at reset release and held
`timescale 1ns/1ps
`default_nettype none
`include "hcps_map.svh"
module hcps_charge_power
    import hcps_pkg::*;
#(
    parameter int PORTS = `HCPS_PORTS,
    parameter int VBUS_FILT = `HCPS_VBUS_FILT_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // configuration bits
    input wire logic [PORTS-1:0] chargePortEnable,
    input wire logic autoChargerDisableN,
    input wire logic highCurrentDividerEnable,
    input wire logic powerSwitchingDisableN,
    input wire logic gangedSelect,
    input wire logic powerEnablePolarity,
    input wire logic useStraps,
    // straps, sampled once after reset
    input wire logic powerSwitchingStrapN,
    input wire logic gangedStrap,
    input wire logic powerPolarityStrap,
    input wire logic serialModeStrap,
    input wire logic [PORTS-1:0] chargeEnableStrap,
    // otp load port
    input wire logic otpLoad,
    input wire logic [15:0] otpVendorId,
    input wire logic [15:0] otpProductId,
    input wire logic [PORTS-1:0] otpRemovableStored,
    input wire logic otpAutoEnable,
    input wire logic otpHighCurrent,
    input wire logic [`HCPS_OTP_PWRON_DLY_W-1:0] otpPwrOnDelay,
    // otp programming request from the usb control pipe
    input wire logic otpProgReq,
    input wire logic [7:0] otpProgAddr,
    input wire logic [7:0] otpProgData,
    output logic otpProgStrobe,
    output logic [7:0] otpProgAddrOut,
    output logic [7:0] otpProgDataOut,
    // link and port status
    input wire logic vbusAbove4V,
    input wire logic upSuperSpeed,
    input wire logic upHighSpeed,
    input wire logic [PORTS-1:0] portPowerRequest,
    input wire logic [PORTS-1:0] overCurrentN,
    input wire logic [PORTS-1:0] devWantsDivider,
    // outputs
    output logic [2*PORTS-1:0] chargeMode,
    output logic [PORTS-1:0] dividerActive,
    output logic [PORTS-1:0] dividerHighCurrent,
    output logic [PORTS-1:0] port_power_enable_out,
    output logic [PORTS-1:0] overCurrentFlag,
    output logic [PORTS-1:0] dsSuperSpeedEnable,
    output logic [PORTS-1:0] dsHighSpeedEnable,
    output logic [PORTS-1:0] portRemovable,
    output logic [15:0] vendorId,
    output logic [15:0] productId,
    output logic [`HCPS_OTP_PWRON_DLY_W-1:0] pwrOnDelay,
    output logic serialModeHeld
);
    // ******************************************************************
    // strap capture and vbus filter
    // ******************************************************************
    localparam int SW = 4 + PORTS;
    logic [SW-1:0] strapHeld;
    logic strapValid;
    logic vbusStable;

    hcps_strap_latch #(.W(SW)) uStrap (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .strapIn({chargeEnableStrap, serialModeStrap, powerPolarityStrap, gangedStrap,
                  powerSwitchingStrapN}),
        .strapHeld(strapHeld),
        .strapValid(strapValid)
    );

    hcps_vbus_filter #(.FILT_CYCLES(VBUS_FILT)) uVbus (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .vbusRaw(vbusAbove4V),
        .vbusStable(vbusStable)
    );

    // ******************************************************************
    // otp loaded fields
    // ******************************************************************
    logic autoDisOtp_r;
    logic hiCurOtp_r;
    logic otpSeen_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vendorId <= `HCPS_ID_RESET;
            productId <= `HCPS_ID_RESET;
            portRemovable <= `HCPS_RST_RMBL;
            autoDisOtp_r <= `HCPS_RST_AUTO_DIS_N;
            hiCurOtp_r <= `HCPS_RST_HICUR;
            pwrOnDelay <= `HCPS_RST_PWRON_DLY;
            otpSeen_r <= 1'b0;
        end else if (clkEn && otpLoad) begin
            // nothing else in the block can be reached from otp
            vendorId <= otpVendorId;
            productId <= otpProductId;
            portRemovable <= ~otpRemovableStored;
            autoDisOtp_r <= ~otpAutoEnable;
            hiCurOtp_r <= otpHighCurrent;
            pwrOnDelay <= otpPwrOnDelay;
            otpSeen_r <= 1'b1;
        end
    end

    // host vendor request passes to the otp writer one cycle later, one pulse each
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            otpProgStrobe <= 1'b0;
            otpProgAddrOut <= 8'h00;
            otpProgDataOut <= 8'h00;
        end else if (clkEn) begin
            otpProgStrobe <= otpProgReq;
            if (otpProgReq) begin
                otpProgAddrOut <= otpProgAddr;
                otpProgDataOut <= otpProgData;
            end
        end
    end

    // ******************************************************************
    // effective configuration
    // ******************************************************************
    logic autoDisEff;
    logic hiCurEff;
    logic swDisableN;
    logic gangedEff;
    logic polEff;
    logic [PORTS-1:0] chgEnEff;
    always_comb begin
        // otp values override register bits once loaded
        autoDisEff = otpSeen_r ? autoDisOtp_r : autoChargerDisableN;
        hiCurEff = otpSeen_r ? hiCurOtp_r : highCurrentDividerEnable;
        swDisableN = useStraps ? strapHeld[0] : powerSwitchingDisableN;
        gangedEff = useStraps ? strapHeld[1] : gangedSelect;
        polEff = useStraps ? strapHeld[2] : powerEnablePolarity;
        chgEnEff = chargePortEnable | (strapValid ? strapHeld[SW-1:4] : '0);
    end
    assign serialModeHeld = strapHeld[3];

    // ******************************************************************
    // charging mode per port
    // ******************************************************************
    function automatic hcps_bc_e selMode(input logic en, input logic vb, input logic dis);
        hcps_bc_e m;
        m = HCPS_BC_NONE;
        if (en) begin
            if (!vb) begin
                m = dis ? HCPS_BC_DCP : HCPS_BC_AUTO;
            end else if (dis) begin
                m = HCPS_BC_CDP;
            end
        end
        return m;
    endfunction : selMode

    hcps_bc_e portMode [PORTS];
    always_comb begin
        for (int i = 0; i < PORTS; i++) begin
            portMode[i] = selMode(chgEnEff[i], vbusStable, autoDisEff);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chargeMode <= '0;
            dividerActive <= '0;
            dividerHighCurrent <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < PORTS; i++) begin
                chargeMode[2*i +: 2] <= 2'(portMode[i]);
                // auto mode swaps divider and dcp as the device asks
                dividerActive[i] <= (portMode[i] == HCPS_BC_AUTO) && devWantsDivider[i];
                // low means the 5 W level, high the 10 W level
                dividerHighCurrent[i] <= (portMode[i] == HCPS_BC_AUTO) && devWantsDivider[i]
                                         && hiCurEff;
            end
        end
    end

    // ******************************************************************
    // port power switch
    // ******************************************************************
    logic [PORTS-1:0] powerOn;
    always_comb begin
        powerOn = '0;
        if (!swDisableN) begin
            if (gangedEff) begin
                // ganged: any request powers all, any fault drops all
                powerOn = ((|portPowerRequest) && (&overCurrentN)) ? '1 : '0;
            end else begin
                powerOn = portPowerRequest & overCurrentN;
            end
        end else begin
            // switching unsupported: ports stay powered
            powerOn = '1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_power_enable_out <= '0;
            overCurrentFlag <= '0;
        end else if (clkEn) begin
            port_power_enable_out <= polEff ? powerOn : ~powerOn;
            overCurrentFlag <= ~overCurrentN;
        end
    end

    // ******************************************************************
    // downstream speed limits
    // ******************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dsSuperSpeedEnable <= '0;
            dsHighSpeedEnable <= '0;
        end else if (clkEn) begin
            dsSuperSpeedEnable <= upSuperSpeed ? '1 : '0;
            dsHighSpeedEnable <= (upSuperSpeed || upHighSpeed) ? '1 : '0;
        end
    end
endmodule : hcps_charge_power
`default_nettype wire

// ### hcps_host_model.sv
// host model: issues vendor programming writes toward the hub
// assumes the bench calls issue between other activity
`timescale 1ns/1ps
`default_nettype none
module hcps_host_model (
    // clock
    input wire logic ref_clk,
    // programming request
    output logic otpProgReq,
    output logic [7:0] otpProgAddr,
    output logic [7:0] otpProgData
);
    initial begin
        otpProgReq = 1'h0;
        otpProgAddr = 8'h00;
        otpProgData = 8'hFF;
    end
    // idle fields flip so a stale value never passes for a capture
    task automatic issue(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        otpProgReq = 1'h1;
        otpProgAddr = a;
        otpProgData = d;
        @(negedge ref_clk);
        otpProgReq = 1'h0;
        otpProgAddr = ~a;
        otpProgData = ~d;
    endtask : issue
endmodule : hcps_host_model
`default_nettype wire

// ### hcps_charge_power_monitor.sv
// checker for the charge and power select block
// assumes two downstream ports; checks pause while clkEn is low
`timescale 1ns/1ps
`default_nettype none
module hcps_charge_power_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // watched ports
    input wire logic otpProgReq,
    input wire logic [7:0] otpProgAddr,
    input wire logic otpProgStrobe,
    input wire logic [7:0] otpProgAddrOut,
    input wire logic [1:0] overCurrentN,
    input wire logic [1:0] overCurrentFlag,
    input wire logic [3:0] chargeMode,
    input wire logic autoChargerDisableN,
    input wire logic upSuperSpeed,
    input wire logic upHighSpeed,
    input wire logic [1:0] dsSuperSpeedEnable,
    input wire logic [1:0] dsHighSpeedEnable,
    input wire logic useStraps,
    input wire logic powerSwitchingDisableN,
    input wire logic gangedSelect,
    input wire logic powerEnablePolarity,
    input wire logic [1:0] port_power_enable_out
);
    logic settled_r;
    // first edge after reset would see reset-time inputs through past values
    always_ff @(posedge ref_clk) begin
        settled_r <= !rst && clkEn;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    // a frozen cycle breaks the one-cycle relations, so skip it and the one after
    default disable iff (rst || !settled_r || !clkEn);
    a_prog_strobe: assert property (otpProgReq |=> otpProgStrobe ##1 !otpProgStrobe)
        else $error("strobe not one cycle after request");
    a_prog_cause: assert property (otpProgStrobe |-> $past(otpProgReq))
        else $error("strobe without request");
    a_prog_addr: assert property (otpProgReq |=> otpProgAddrOut == $past(otpProgAddr))
        else $error("address not passed on");
    a_oc_flag: assert property (overCurrentFlag == ~$past(overCurrentN))
        else $error("overcurrent flag wrong");
    a_no_cdp_auto: assert property (
        (chargeMode[1:0] == 2'h3 || chargeMode[3:2] == 2'h3) |-> $past(autoChargerDisableN))
        else $error("cdp while automatic mode on");
    a_ss_limit: assert property (!$past(upSuperSpeed) |-> dsSuperSpeedEnable == 2'h0)
        else $error("superspeed left on");
    a_hs_limit: assert property (
        !$past(upSuperSpeed) && !$past(upHighSpeed) |-> dsHighSpeedEnable == 2'h0)
        else $error("high speed left on");
    a_ganged_same: assert property (
        !$past(useStraps) && $past(gangedSelect)
        |-> port_power_enable_out[0] == port_power_enable_out[1])
        else $error("ganged outputs differ");
    a_switch_off: assert property (
        !$past(useStraps) && $past(powerSwitchingDisableN)
        |-> port_power_enable_out == {2{$past(powerEnablePolarity)}})
        else $error("unswitched ports not powered");
endmodule : hcps_charge_power_monitor
bind hcps_charge_power hcps_charge_power_monitor u_mon (.*);
`default_nettype wire

// ### test_hcps_charge_power.sv
// bench for the charge and power select block
// assumes host model and checker compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "hcps_map.svh"
module test_hcps_charge_power;
    // ****
    // signals
    // ****
    logic ref_clk = 1'h0, rst = 1'h1, clkEn = 1'h1, otpLoad = 1'h0;
    logic [1:0] chargePortEnable = 2'h0, chargeEnableStrap = 2'h0, otpRemovableStored = 2'h0;
    logic autoChargerDisableN = 1'h0, highCurrentDividerEnable = 1'h0;
    logic powerSwitchingDisableN = 1'h0, gangedSelect = 1'h0, powerEnablePolarity = 1'h1;
    logic useStraps = 1'h0, powerSwitchingStrapN = 1'h0, gangedStrap = 1'h1;
    logic powerPolarityStrap = 1'h0, serialModeStrap = 1'h1, otpAutoEnable = 1'h1;
    logic otpHighCurrent = 1'h1, otpProgReq, otpProgStrobe, serialModeHeld;
    logic [15:0] otpVendorId = 16'h0000, otpProductId = 16'h0000, vendorId, productId;
    logic [`HCPS_OTP_PWRON_DLY_W-1:0] otpPwrOnDelay = 3'h0, pwrOnDelay;
    logic [7:0] otpProgAddr, otpProgData, otpProgAddrOut, otpProgDataOut;
    logic vbusAbove4V = 1'h0, upSuperSpeed = 1'h1, upHighSpeed = 1'h1;
    logic [1:0] portPowerRequest = 2'h0, overCurrentN = 2'h3, devWantsDivider = 2'h0;
    logic [1:0] dividerActive, dividerHighCurrent, port_power_enable_out, overCurrentFlag;
    logic [1:0] dsSuperSpeedEnable, dsHighSpeedEnable, portRemovable;
    logic [3:0] chargeMode;
    int fail_count = 0, checked = 0, cycles = 0;
    // short filter keeps the vbus waits brief
    hcps_charge_power #(.VBUS_FILT(2)) u_dut (.*);
    hcps_host_model u_host (.ref_clk(ref_clk), .otpProgReq(otpProgReq),
        .otpProgAddr(otpProgAddr), .otpProgData(otpProgData));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        step(10);
        rst = 1'h0;
        step(2);
        {powerSwitchingStrapN, gangedStrap, powerPolarityStrap, serialModeStrap} = 4'hA;
        step(2);
        chk(serialModeHeld, 1'h1);
        portPowerRequest = 2'h1;
        step(2);
        chk(port_power_enable_out, 2'h1);
        powerEnablePolarity = 1'h0;
        step(2);
        chk(port_power_enable_out, 2'h2);
        gangedSelect = 1'h1;
        step(2);
        chk(port_power_enable_out, 2'h0);
        overCurrentN = 2'h2;
        step(3);
        chk(port_power_enable_out, 2'h3);
        chk(overCurrentFlag, 2'h1);
        overCurrentN = 2'h3;
        powerEnablePolarity = 1'h1;
        powerSwitchingDisableN = 1'h1;
        step(3);
        chk(port_power_enable_out, 2'h3);
        useStraps = 1'h1;
        step(2);
        chk(port_power_enable_out, 2'h0);
        portPowerRequest = 2'h0;
        step(2);
        chk(port_power_enable_out, 2'h3);
        for (int i = 0; i < 3; i++) begin
            {upSuperSpeed, upHighSpeed} = 2'h3 >> i;
            step(2);
            chk(dsSuperSpeedEnable, (i == 0) ? 2'h3 : 2'h0);
            chk(dsHighSpeedEnable, (i == 2) ? 2'h0 : 2'h3);
        end
        {upSuperSpeed, upHighSpeed} = 2'h3;
        chk(chargeMode, 4'h0);
        chargePortEnable = 2'h1;
        step(2);
        chk(chargeMode, 4'h1);
        devWantsDivider = 2'h1;
        step(2);
        chk(dividerActive, 2'h1);
        chk(dividerHighCurrent, 2'h0);
        highCurrentDividerEnable = 1'h1;
        step(2);
        chk(dividerHighCurrent, 2'h1);
        devWantsDivider = 2'h0;
        autoChargerDisableN = 1'h1;
        step(2);
        chk(dividerActive, 2'h0);
        chk(chargeMode, 4'h2);
        vbusAbove4V = 1'h1;
        step(1);
        vbusAbove4V = 1'h0;
        step(10);
        chk(chargeMode, 4'h2);
        vbusAbove4V = 1'h1;
        step(10);
        chk(chargeMode, 4'h3);
        autoChargerDisableN = 1'h0;
        step(2);
        chk(chargeMode, 4'h0);
        chargePortEnable = 2'h0;
        vbusAbove4V = 1'h0;
        {otpVendorId, otpProductId} = 32'h1234_5678;
        otpRemovableStored = 2'h1;
        otpPwrOnDelay = 3'h5;
        otpLoad = 1'h1;
        step(1);
        otpLoad = 1'h0;
        step(1);
        chk(vendorId, 16'h1234);
        chk(productId, 16'h5678);
        chk(portRemovable, 2'h2);
        chk(pwrOnDelay, 3'h5);
        u_host.issue(8'h5A, 8'hC3);
        chk(otpProgStrobe, 1'h1);
        chk({otpProgAddrOut, otpProgDataOut}, 16'h5AC3);
        step(1);
        chk(otpProgStrobe, 1'h0);
        chargeEnableStrap = 2'h2;
        autoChargerDisableN = 1'h1;
        rst = 1'h1;
        step(3);
        rst = 1'h0;
        step(3);
        chk(chargeMode, 4'h8);
        // clock enable low must freeze the mode; it follows once enabled again
        clkEn = 1'h0;
        chargePortEnable = 2'h1;
        step(3);
        chk(chargeMode, 4'h8);
        clkEn = 1'h1;
        step(2);
        chk(chargeMode, 4'hA);
        complete_run();
    end
endmodule : test_hcps_charge_power
`default_nettype wire
